// ==== hw/cmw_pkg.sv ====
// Package for the CAN mode and window control block: offsets, fields, reset values, codes.
// Assumes a plain register port driven by a processor on the same clock.
package cmw_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_OFFSET = 4'h1;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 5;
   localparam int ABORT_BIT = 4;
   localparam int WIN_MSB = 3;
   localparam int WIN_LSB = 1;
   localparam logic [7:0] CTRL_RESET = 8'h80;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [2:0] MODE_LISTEN = 3'h3;
   localparam logic [2:0] MODE_LOOPBACK = 3'h2;
   localparam logic [2:0] MODE_DISABLE = 3'h1;
   localparam logic [2:0] MODE_NORMAL = 3'h0;

   typedef enum logic [4:0] {
      OP_NORMAL   = 5'h01,
      OP_DISABLE  = 5'h02,
      OP_LOOPBACK = 5'h04,
      OP_LISTEN   = 5'h08,
      OP_CONFIG   = 5'h10
   } cmw_mode_e;

   typedef enum logic [4:0] {
      BUF_RX0 = 5'h01,
      BUF_RX1 = 5'h02,
      BUF_TX0 = 5'h04,
      BUF_TX1 = 5'h08,
      BUF_TX2 = 5'h10
   } cmw_buf_e;

endpackage : cmw_pkg

// ==== hw/cmw_ctrl_if.sv ====
// Interface carrying control fields from register file to decoders and their decoded values back.
// Assumes one clock domain; carries levels only.
`timescale 1ns/1ps
interface cmw_ctrl_if;
   logic [2:0] modeRequestField;
   logic [2:0] bufferWindowSelect;
   cmw_pkg::cmw_mode_e modeReq;
   cmw_pkg::cmw_buf_e windowBuf;
   modport regs (output modeRequestField, output bufferWindowSelect,
                 input modeReq, input windowBuf);
   modport dec (input modeRequestField, input bufferWindowSelect,
                output modeReq, output windowBuf);
endinterface : cmw_ctrl_if

// ==== hw/cmw_decode.sv ====
// Combinational decode of mode request and window select fields.
// Assumes field values come from registers on the same clock.
`timescale 1ns/1ps
module cmw_decode (
   // Fields in, decoded out
   cmw_ctrl_if.dec ctrl
);

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   always_comb begin
      if (ctrl.modeRequestField[2]) begin
         ctrl.modeReq = cmw_pkg::OP_CONFIG;
      end else if (ctrl.modeRequestField == cmw_pkg::MODE_LISTEN) begin
         ctrl.modeReq = cmw_pkg::OP_LISTEN;
      end else if (ctrl.modeRequestField == cmw_pkg::MODE_LOOPBACK) begin
         ctrl.modeReq = cmw_pkg::OP_LOOPBACK;
      end else if (ctrl.modeRequestField == cmw_pkg::MODE_DISABLE) begin
         ctrl.modeReq = cmw_pkg::OP_DISABLE;
      end else begin
         ctrl.modeReq = cmw_pkg::OP_NORMAL;
      end
   end

   // ----------------------------------------
   // Window decode
   // ----------------------------------------
   always_comb begin
      case (ctrl.bufferWindowSelect)
         3'h5: ctrl.windowBuf = cmw_pkg::BUF_RX1;
         3'h4: ctrl.windowBuf = cmw_pkg::BUF_TX0;
         3'h3: ctrl.windowBuf = cmw_pkg::BUF_TX1;
         3'h2: ctrl.windowBuf = cmw_pkg::BUF_TX2;
         default: ctrl.windowBuf = cmw_pkg::BUF_RX0;
      endcase
   end

endmodule : cmw_decode

// ==== hw/cmw_mode_window.sv ====
// Top of the CAN mode and window control block: control register, abort, decoded outputs.
// Assumes the processor port and the pending-transmit inputs share mclk.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cmw_mode_window (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [cmw_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Transmit buffer state from the protocol side
   input wire logic [2:0] txPending,
   // Control outputs
   output logic [4:0] opModeReq,
   output logic [4:0] windowBufSel,
   output logic [2:0] windowCode,
   output logic abortAllTx
);

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [2:0] mode_reg;
   logic abort_reg;
   logic [2:0] win_reg;
   logic ctrlWr;
   logic [7:0] ctrlView;

   cmw_ctrl_if ctrl ();

   assign ctrlWr = regWr && (regAddr == cmw_pkg::CTRL_OFFSET);
   assign ctrl.modeRequestField = mode_reg;
   assign ctrl.bufferWindowSelect = win_reg;
   // Bit zero is not stored, so it always reads back zero
   assign ctrlView = {mode_reg, abort_reg, win_reg, 1'b0};

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg <= cmw_pkg::CTRL_RESET[cmw_pkg::MODE_MSB:cmw_pkg::MODE_LSB];
      end else if (ctrlWr) begin
         mode_reg <= regWdata[cmw_pkg::MODE_MSB:cmw_pkg::MODE_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         win_reg <= cmw_pkg::CTRL_RESET[cmw_pkg::WIN_MSB:cmw_pkg::WIN_LSB];
      end else if (ctrlWr) begin
         win_reg <= regWdata[cmw_pkg::WIN_MSB:cmw_pkg::WIN_LSB];
      end
   end

   // Abort is a software level: it stays set until software clears it,
   // so the cancel holds for every buffer queued meanwhile.
   always_ff @(posedge mclk) begin
      if (rst) begin
         abort_reg <= cmw_pkg::CTRL_RESET[cmw_pkg::ABORT_BIT];
      end else if (ctrlWr) begin
         abort_reg <= regWdata[cmw_pkg::ABORT_BIT];
      end
   end

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   cmw_decode u_decode (
      .ctrl(ctrl.dec)
   );

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         opModeReq <= cmw_pkg::OP_CONFIG;
         windowBufSel <= cmw_pkg::BUF_RX0;
         windowCode <= cmw_pkg::CTRL_RESET[cmw_pkg::WIN_MSB:cmw_pkg::WIN_LSB];
      end else begin
         opModeReq <= ctrl.modeReq;
         windowBufSel <= ctrl.windowBuf;
         windowCode <= win_reg;
      end
   end

   // ----------------------------------------
   // Transmit abort
   // ----------------------------------------
   logic [2:0] txCancel;

   // One cancel request per transmit buffer, so every pending buffer is hit
   for (genvar b = 0; b < 3; b++) begin : g_cancel
      assign txCancel[b] = abort_reg && txPending[b];
   end

   // Cancel only while something is pending; zero lets queue run
   always_ff @(posedge mclk) begin
      if (rst) begin
         abortAllTx <= 1'b0;
      end else begin
         abortAllTx <= |txCancel;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRd && regAddr == cmw_pkg::CTRL_OFFSET) begin
         regRdata <= ctrlView;
      end else if (regRd && regAddr == cmw_pkg::STAT_OFFSET) begin
         regRdata <= {3'h0, abortAllTx, 1'b0, txPending};
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule : cmw_mode_window

// ==== verification/cmw_monitor.sv ====
// Checker for cmw_mode_window: field decode, abort and readback timing.
// Bound to the top module; one clock, reset high.
`timescale 1ns/1ps
module cmw_monitor (
   // Watched ports
   input wire logic mclk,
   input wire logic rst,
   input wire logic [cmw_pkg::ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic [2:0] txPending,
   input wire logic [4:0] opModeReq,
   input wire logic [4:0] windowBufSel,
   input wire logic [2:0] windowCode,
   input wire logic abortAllTx
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic w0;
   // Decoded outputs trail a control write by two edges
   assign w0 = regWr && regAddr == cmw_pkg::CTRL_OFFSET;
   property p_cfg; w0 && regWdata[7] |-> ##2 opModeReq == 5'h10; endproperty
   a_cfg: assert property (p_cfg) else $error("mode");
   property p_lst; w0 && regWdata[7:5] == 3'h3 |-> ##2 opModeReq == 5'h08; endproperty
   a_lst: assert property (p_lst) else $error("listen");
   property p_abt;
      w0 && regWdata[4] && |txPending ##1 (!w0 && |txPending)[*2] |-> abortAllTx;
   endproperty
   a_abt: assert property (p_abt) else $error("abort");
   property p_run; w0 && !regWdata[4] ##1 !w0 |-> ##1 !abortAllTx; endproperty
   a_run: assert property (p_run) else $error("run");
   property p_rx0;
      w0 && regWdata[3:1] inside {3'h7, 3'h6, 3'h1, 3'h0} |-> ##2 windowBufSel == 5'h01;
   endproperty
   a_rx0: assert property (p_rx0) else $error("rx0");
   property p_rx1; w0 && regWdata[3:1] == 3'h5 |-> ##2 windowBufSel == 5'h02; endproperty
   a_rx1: assert property (p_rx1) else $error("rx1");
   property p_tx2; w0 && regWdata[3:1] == 3'h2 |-> ##2 windowBufSel == 5'h10; endproperty
   a_tx2: assert property (p_tx2) else $error("tx2");
   property p_code; w0 |-> ##2 windowCode == $past(regWdata[3:1], 2); endproperty
   a_code: assert property (p_code) else $error("code");
   property p_bit0;
      regRd && regAddr == cmw_pkg::CTRL_OFFSET |=> regRdata[0] == 1'b0;
   endproperty
   a_bit0: assert property (p_bit0) else $error("bit0");
   c_abt: cover property (abortAllTx);
   c_lst: cover property (opModeReq == 5'h08);
   c_tx1: cover property (windowBufSel == 5'h08);
endmodule : cmw_monitor
bind cmw_mode_window cmw_monitor cmw_monitor_i (
   .mclk(mclk),
   .rst(rst),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .regWr(regWr),
   .regRd(regRd),
   .regRdata(regRdata),
   .txPending(txPending),
   .opModeReq(opModeReq),
   .windowBufSel(windowBufSel),
   .windowCode(windowCode),
   .abortAllTx(abortAllTx)
);

// ==== verification/cmw_mode_window_tb.sv ====
// Testbench for cmw_mode_window: random control writes against a bench model.
// Drives the register port itself; 100 ns clock.
`timescale 1ns/1ps
module cmw_mode_window_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [cmw_pkg::ADDR_W-1:0] regAddr = '0;
   logic [7:0] regWdata = 8'h00, regRdata, lfsr = 8'h5d, q, ctrlModel = 8'h80;
   logic regWr = 1'b0, regRd = 1'b0, abortAllTx;
   logic [2:0] txPending = 3'h0, windowCode;
   logic [4:0] opModeReq, windowBufSel;
   int nErrors = 0, checksDone = 0;
   logic [7:0] expQ[$];
   always #50 mclk = ~mclk;
   cmw_mode_window cmw_mode_window_i (
      .mclk(mclk),
      .rst(rst),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWr(regWr),
      .regRd(regRd),
      .regRdata(regRdata),
      .txPending(txPending),
      .opModeReq(opModeReq),
      .windowBufSel(windowBufSel),
      .windowCode(windowCode),
      .abortAllTx(abortAllTx)
   );
   function automatic logic [7:0] lfsrNext(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsrNext
   function automatic logic [7:0] ewin(input logic [2:0] w);
      return w == 3'h5 ? 8'h02 : w == 3'h4 ? 8'h04 : w == 3'h3 ? 8'h08 : w == 3'h2 ? 8'h10 : 8'h01;
   endfunction : ewin
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checksDone++;
      if (s !== e) begin
         nErrors++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : chk
   task automatic stopTest;
      if (nErrors == 0 && checksDone > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stopTest
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   // Read data stand only in the cycle after the strobe edge: taken mid-cycle
   task automatic rd(input logic [3:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      q = regRdata;
      @(posedge mclk);
   endtask : rd
   task automatic outs;
      @(negedge mclk);
      chk("mode", {3'h0, opModeReq},
          ctrlModel[7] ? 8'h10 : 8'h01 << ctrlModel[6:5]);
      chk("window", {3'h0, windowBufSel}, ewin(ctrlModel[3:1]));
      chk("code", {5'h00, windowCode}, {5'h00, ctrlModel[3:1]});
      chk("abort", {7'h00, abortAllTx}, {7'h00, ctrlModel[4] && |txPending});
      @(posedge mclk);
   endtask : outs
   initial begin
      expQ.push_back(8'h80);
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 300; i++) begin
         rd(4'h0);
         chk("control", q, expQ.pop_front());
         outs();
         if (i % 60 == 0) begin
            rd(4'h1);
            chk("status", q, {3'h0, ctrlModel[4] && |txPending, 1'b0, txPending});
            wr(4'h9, 8'h00);
            rd(4'h9);
            chk("unmapped", q, 8'h00);
         end
         lfsr = lfsrNext(lfsr);
         txPending <= lfsr[2:0] ^ lfsr[7:5];
         // The random window field stands in for a copied interrupt source code
         wr(4'h0, lfsr);
         ctrlModel = lfsr & 8'hfe;
         expQ.push_back(ctrlModel);
         if (i == 150) begin
            rst <= 1'b1;
            @(posedge mclk);
            rst <= 1'b0;
            ctrlModel = 8'h80;
            expQ.delete();
            expQ.push_back(ctrlModel);
         end
      end
      stopTest();
   end
endmodule : cmw_mode_window_tb
